// ### core/pcpsr_top.sv
// phase compensation and power sign register bank on apb
//
// Chosen here: the APB interface to the registers.
`include "pcpsr_params.svh"
`timescale 1ns/1ps
module pcpsr_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [17:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     pwr_valid,
  input  wire pcpsr_pkg::pcpsr_pwr_type active_a,
  input  wire pcpsr_pkg::pcpsr_pwr_type active_b,
  input  wire pcpsr_pkg::pcpsr_pwr_type active_c,
  input  wire pcpsr_pkg::pcpsr_pwr_type reactive_a,
  input  wire pcpsr_pkg::pcpsr_pwr_type reactive_b,
  input  wire pcpsr_pkg::pcpsr_pwr_type reactive_c,
  input  wire pcpsr_pkg::pcpsr_pwr_type reactive_fund_a,
  input  wire pcpsr_pkg::pcpsr_pwr_type apparent_a,
  input  wire pcpsr_pkg::pcpsr_pwr_type apparent_b,
  input  wire pcpsr_pkg::pcpsr_pwr_type apparent_c,
  output logic [8:0]                    comp_eff_a,
  output logic [8:0]                    comp_eff_b,
  output logic [8:0]                    comp_eff_c,
  output logic                          comp_volt_a,
  output logic                          comp_volt_b,
  output logic                          comp_volt_c,
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'h0};
  endfunction

  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic hit_comp_a;
  logic hit_comp_b;
  logic hit_comp_c;
  logic hit_sign;
  logic hit_pulse;
  logic hit_computation_mode_reg;
  logic hit_accumulation_mode_reg;
  logic hit_irq_stat;
  logic hit_irq_en;
  logic hit_irq_clr;
  logic hit_any;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite;

  assign hit_comp_a   = paddr == byte_addr(`PCPSR_IDX_COMP_A);
  assign hit_comp_b   = paddr == byte_addr(`PCPSR_IDX_COMP_B);
  assign hit_comp_c   = paddr == byte_addr(`PCPSR_IDX_COMP_C);
  assign hit_sign     = paddr == byte_addr(`PCPSR_IDX_SIGN);
  assign hit_pulse    = paddr == byte_addr(`PCPSR_IDX_PULSE);
  assign hit_computation_mode_reg = paddr == byte_addr(`PCPSR_IDX_COMPUTATION_MODE_REG);
  assign hit_accumulation_mode_reg  = paddr == byte_addr(`PCPSR_IDX_ACCUMULATION_MODE_REG);
  assign hit_irq_stat = paddr == byte_addr(`PCPSR_IDX_IRQ_STAT);
  assign hit_irq_en   = paddr == byte_addr(`PCPSR_IDX_IRQ_EN);
  assign hit_irq_clr  = paddr == byte_addr(`PCPSR_IDX_IRQ_CLR);

  assign hit_any = hit_comp_a | hit_comp_b | hit_comp_c | hit_sign
                 | hit_pulse | hit_computation_mode_reg | hit_accumulation_mode_reg
                 | hit_irq_stat | hit_irq_en | hit_irq_clr;

  ////////////////////////////////////////////////////////////////////
  // software registers

  logic wr_comp_a;
  logic wr_comp_b;
  logic wr_comp_c;
  logic wr_pulse;
  logic wr_computation_mode_reg;
  logic wr_accumulation_mode_reg;
  logic wr_irq_en;
  logic wr_irq_clr;

  assign wr_comp_a   = wr_access && hit_comp_a;
  assign wr_comp_b   = wr_access && hit_comp_b;
  assign wr_comp_c   = wr_access && hit_comp_c;
  assign wr_pulse    = wr_access && hit_pulse;
  assign wr_computation_mode_reg = wr_access && hit_computation_mode_reg;
  assign wr_accumulation_mode_reg  = wr_access && hit_accumulation_mode_reg;
  assign wr_irq_en   = wr_access && hit_irq_en;
  assign wr_irq_clr  = wr_access && hit_irq_clr;

  pcpsr_pkg::pcpsr_code_type comp_a_reg;
  pcpsr_pkg::pcpsr_code_type comp_b_reg;
  pcpsr_pkg::pcpsr_code_type comp_c_reg;
  logic [15:0]               pulse_reg;
  logic [8:0]                computation_mode_reg_reg;
  logic [7:0]                accumulation_mode_reg_reg;
  pcpsr_pkg::pcpsr_sign_type irq_en_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_a_reg <= `PCPSR_COMP_RST;
    end else if (wr_comp_a) begin
      comp_a_reg <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_b_reg <= `PCPSR_COMP_RST;
    end else if (wr_comp_b) begin
      comp_b_reg <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_c_reg <= `PCPSR_COMP_RST;
    end else if (wr_comp_c) begin
      comp_c_reg <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= `PCPSR_PULSE_RST;
    end else if (wr_pulse) begin
      pulse_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      computation_mode_reg_reg <= `PCPSR_COMPUTATION_MODE_REG_RST;
    end else if (wr_computation_mode_reg) begin
      computation_mode_reg_reg <= pwdata[8:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulation_mode_reg_reg <= `PCPSR_ACCUMULATION_MODE_REG_RST;
    end else if (wr_accumulation_mode_reg) begin
      accumulation_mode_reg_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= '0;
    end else if (wr_irq_en) begin
      irq_en_reg <= pwdata[8:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compensation code mapping

  pcpsr_comp_map u_map_a (
    .code (comp_a_reg),
    .eff  (comp_eff_a),
    .volt (comp_volt_a)
  );

  pcpsr_comp_map u_map_b (
    .code (comp_b_reg),
    .eff  (comp_eff_b),
    .volt (comp_volt_b)
  );

  pcpsr_comp_map u_map_c (
    .code (comp_c_reg),
    .eff  (comp_eff_c),
    .volt (comp_volt_c)
  );

  ////////////////////////////////////////////////////////////////////
  // power values to the path sign units

  pcpsr_pwr_if pwr_bus ();

  assign pwr_bus.act[0] = active_a;
  assign pwr_bus.act[1] = active_b;
  assign pwr_bus.act[2] = active_c;
  assign pwr_bus.rea[0] = reactive_a;
  assign pwr_bus.rea[1] = reactive_b;
  assign pwr_bus.rea[2] = reactive_c;
  assign pwr_bus.app[0] = apparent_a;
  assign pwr_bus.app[1] = apparent_b;
  assign pwr_bus.app[2] = apparent_c;

  logic path1_neg;
  logic path2_neg;
  logic path3_neg;

  pcpsr_path_sign u_path1 (
    .pwr       (pwr_bus),
    .phase_sel (computation_mode_reg_reg[`PCPSR_PATH1_LSB +: 3]),
    .type_sel  (pulse_reg[`PCPSR_PATH1_LSB +: 3]),
    .neg       (path1_neg)
  );

  pcpsr_path_sign u_path2 (
    .pwr       (pwr_bus),
    .phase_sel (computation_mode_reg_reg[`PCPSR_PATH2_LSB +: 3]),
    .type_sel  (pulse_reg[`PCPSR_PATH2_LSB +: 3]),
    .neg       (path2_neg)
  );

  pcpsr_path_sign u_path3 (
    .pwr       (pwr_bus),
    .phase_sel (computation_mode_reg_reg[`PCPSR_PATH3_LSB +: 3]),
    .type_sel  (pulse_reg[`PCPSR_PATH3_LSB +: 3]),
    .neg       (path3_neg)
  );

  ////////////////////////////////////////////////////////////////////
  // sign status

  logic                      rea_a_src_fund;
  pcpsr_pkg::pcpsr_pwr_type  rea_a_sel;
  pcpsr_pkg::pcpsr_sign_type sign_reg;
  pcpsr_pkg::pcpsr_sign_type sign_next;

  assign rea_a_src_fund = accumulation_mode_reg_reg[`PCPSR_RSEL_BIT];
  assign rea_a_sel      = rea_a_src_fund ? reactive_fund_a : reactive_a;

  always_comb begin
    sign_next = '0;
    sign_next[`PCPSR_SIGN_ACT_A]     = active_a[23];
    sign_next[`PCPSR_SIGN_ACT_A + 1] = active_b[23];
    sign_next[`PCPSR_SIGN_ACT_A + 2] = active_c[23];
    sign_next[`PCPSR_SIGN_SUM1]      = path1_neg;
    sign_next[`PCPSR_SIGN_REA_A]     = rea_a_sel[23];
    sign_next[`PCPSR_SIGN_REA_A + 1] = reactive_b[23];
    sign_next[`PCPSR_SIGN_REA_A + 2] = reactive_c[23];
    sign_next[`PCPSR_SIGN_SUM2]      = path2_neg;
    sign_next[`PCPSR_SIGN_SUM3]      = path3_neg;
  end

  // only the datapath strobe updates the signs, never the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sign_reg <= `PCPSR_SIGN_RST;
    end else if (pwr_valid) begin
      sign_reg <= sign_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt status

  pcpsr_pkg::pcpsr_sign_type sign_event;
  pcpsr_pkg::pcpsr_sign_type clr_mask;
  pcpsr_pkg::pcpsr_sign_type irq_stat_reg;
  pcpsr_pkg::pcpsr_sign_type irq_stat_next;

  assign sign_event    = pwr_valid ? (sign_next ^ sign_reg) : '0;
  assign clr_mask      = wr_irq_clr ? pwdata[8:0] : '0;
  assign irq_stat_next = (irq_stat_reg & ~clr_mask) | sign_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////
  // read data and answer

  logic [31:0] rd_comp_a;
  logic [31:0] rd_comp_b;
  logic [31:0] rd_comp_c;
  logic [31:0] rd_sign;
  logic [31:0] rd_pulse;
  logic [31:0] rd_computation_mode_reg;
  logic [31:0] rd_accumulation_mode_reg;
  logic [31:0] rd_irq_stat;
  logic [31:0] rd_irq_en;
  logic [31:0] rd_data;

  assign rd_comp_a   = {22'h0, comp_a_reg};
  assign rd_comp_b   = {22'h0, comp_b_reg};
  assign rd_comp_c   = {22'h0, comp_c_reg};
  assign rd_sign     = {23'h0, sign_reg};
  assign rd_pulse    = {16'h0, pulse_reg};
  assign rd_computation_mode_reg = {23'h0, computation_mode_reg_reg};
  assign rd_accumulation_mode_reg  = {24'h0, accumulation_mode_reg_reg};
  assign rd_irq_stat = {23'h0, irq_stat_reg};
  assign rd_irq_en   = {23'h0, irq_en_reg};

  always_comb begin
    rd_data = '0;
    if (hit_comp_a) begin
      rd_data = rd_comp_a;
    end else if (hit_comp_b) begin
      rd_data = rd_comp_b;
    end else if (hit_comp_c) begin
      rd_data = rd_comp_c;
    end else if (hit_sign) begin
      rd_data = rd_sign;
    end else if (hit_pulse) begin
      rd_data = rd_pulse;
    end else if (hit_computation_mode_reg) begin
      rd_data = rd_computation_mode_reg;
    end else if (hit_accumulation_mode_reg) begin
      rd_data = rd_accumulation_mode_reg;
    end else if (hit_irq_stat) begin
      rd_data = rd_irq_stat;
    end else if (hit_irq_en) begin
      rd_data = rd_irq_en;
    end
  end

  // read data is captured in the setup cycle, so the access cycle ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0 : rd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !hit_any;
    end
  end

  // zero wait states
  assign pready = 1'b1;

endmodule

// ### core/pcpsr_params.svh
// constants for the phase compensation and power sign registers
// What this block does
// - codes 384 to 511 act like the code 128 lower
// - codes 512 to 1023 set the voltage flag, effective code 384 plus code bits 6..0
// - three 10-bit compensation codes, reset zero, bits 15 to 10 unused
// - bits 0 to 2 flag negative active power of phases A, B, C
// - bits 4 to 6 flag negative reactive power of phases A, B, C
// - phase A reactive sign uses total or fundamental per select bit
// - bit 3 flags a negative sum in the first pulse path
// - first path phases from mode bits 2..0, type from first select
// - bit 7 flags second path sum, phases bits 5..3, second select
// - bit 8 flags third path sum, phases bits 8..6, third select
// - sign bits 15 to 9 read zero; sign bits reset zero
// - type select 000 active, 001 reactive, 010 apparent, others active
`ifndef PCPSR_PARAMS_SVH
`define PCPSR_PARAMS_SVH

`define PCPSR_IDX_COMP_A    16'he614
`define PCPSR_IDX_COMP_B    16'he615
`define PCPSR_IDX_COMP_C    16'he616
`define PCPSR_IDX_SIGN      16'he617
`define PCPSR_IDX_PULSE     16'he610
`define PCPSR_IDX_COMPUTATION_MODE_REG  16'he611
`define PCPSR_IDX_ACCUMULATION_MODE_REG   16'he612
`define PCPSR_IDX_IRQ_STAT  16'he620
`define PCPSR_IDX_IRQ_EN    16'he621
`define PCPSR_IDX_IRQ_CLR   16'he622

`define PCPSR_COMP_RST      10'h000
`define PCPSR_PULSE_RST     16'h0e88
`define PCPSR_COMPUTATION_MODE_REG_RST  9'h1ff
`define PCPSR_ACCUMULATION_MODE_REG_RST   8'h00
`define PCPSR_SIGN_RST      9'h000

`define PCPSR_RSEL_BIT      7
`define PCPSR_PATH1_LSB     0
`define PCPSR_PATH2_LSB     3
`define PCPSR_PATH3_LSB     6
`define PCPSR_TYPE_ACT      3'h0
`define PCPSR_TYPE_REA      3'h1
`define PCPSR_TYPE_APP      3'h2

`define PCPSR_SIGN_ACT_A    0
`define PCPSR_SIGN_SUM1     3
`define PCPSR_SIGN_REA_A    4
`define PCPSR_SIGN_SUM2     7
`define PCPSR_SIGN_SUM3     8

`define PCPSR_CODE_HIGH     10'h180
`define PCPSR_CODE_VOLT     10'h200
`define PCPSR_CODE_FOLD     10'h080
`define PCPSR_EFF_VBASE     9'h180

`endif

// ### core/pcpsr_pkg.sv
// types shared by the phase compensation and power sign logic
package pcpsr_pkg;
  typedef logic signed [23:0] pcpsr_pwr_type;
  typedef logic signed [25:0] pcpsr_sum_type;
  typedef logic [9:0]         pcpsr_code_type;
  typedef logic [8:0]         pcpsr_sign_type;
  typedef logic [2:0]         pcpsr_sel_type;
endpackage

// ### core/pcpsr_pwr_if.sv
// per phase power values passed to the path sign logic
`timescale 1ns/1ps
interface pcpsr_pwr_if;
  pcpsr_pkg::pcpsr_pwr_type act [3];
  pcpsr_pkg::pcpsr_pwr_type rea [3];
  pcpsr_pkg::pcpsr_pwr_type app [3];
  modport src (output act, output rea, output app);
  modport snk (input act, input rea, input app);
endinterface

// ### core/pcpsr_comp_map.sv
// maps a written compensation code to its effective code
`include "pcpsr_params.svh"
`timescale 1ns/1ps
module pcpsr_comp_map (
  input  wire pcpsr_pkg::pcpsr_code_type code,
  output logic [8:0]                     eff,
  output logic                           volt
);
  logic high_band;
  logic [8:0] fold_code;
  logic [8:0] volt_code;
  assign high_band = (code >= `PCPSR_CODE_HIGH) && (code < `PCPSR_CODE_VOLT);
  assign fold_code = 9'(code - `PCPSR_CODE_FOLD);
  assign volt_code = `PCPSR_EFF_VBASE | {2'h0, code[6:0]};
  assign volt      = code[9];
  assign eff       = volt ? volt_code : (high_band ? fold_code : code[8:0]);
endmodule

// ### core/pcpsr_path_sign.sv
// sign of the power sum in one pulse-output path
`include "pcpsr_params.svh"
`timescale 1ns/1ps
module pcpsr_path_sign (
  pcpsr_pwr_if.snk                  pwr,
  input  wire pcpsr_pkg::pcpsr_sel_type phase_sel,
  input  wire pcpsr_pkg::pcpsr_sel_type type_sel,
  output logic                          neg
);
  pcpsr_pkg::pcpsr_sum_type sum;
  pcpsr_pkg::pcpsr_pwr_type term [3];

  // power type per phase; spare codes act as active
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (type_sel == `PCPSR_TYPE_REA) begin
        term[i] = pwr.rea[i];
      end else if (type_sel == `PCPSR_TYPE_APP) begin
        term[i] = pwr.app[i];
      end else begin
        term[i] = pwr.act[i];
      end
    end
  end

  // selected phases only
  always_comb begin
    sum = '0;
    for (int i = 0; i < 3; i++) begin
      if (phase_sel[i]) begin
        sum = pcpsr_pkg::pcpsr_sum_type'(sum + 26'(term[i]));
      end
    end
  end

  assign neg = sum[25];
endmodule

// ### sim/pcpsr_top_monitor.sv
// assertion checker for the compensation and sign registers
`include "pcpsr_params.svh"
`timescale 1ns/1ps
module pcpsr_top_monitor (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [17:0]              paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     pwr_valid,
  input wire pcpsr_pkg::pcpsr_pwr_type active_a,
  input wire pcpsr_pkg::pcpsr_pwr_type reactive_c,
  input wire logic [8:0]               comp_eff_a,
  input wire logic                     comp_volt_a
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] seen_reg;
  wire        rd_set = psel && !penable && !pwrite;
  wire        sgn_rd = rd_set && paddr == {`PCPSR_IDX_SIGN, 2'b00};
  wire        cmp_rd = rd_set && paddr == {`PCPSR_IDX_COMP_A, 2'b00};
  wire        cmp_wr = psel && penable && pwrite && paddr == {`PCPSR_IDX_COMP_A, 2'b00};
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 2'h0;
    end else if (pwr_valid) begin
      seen_reg <= {active_a[23], reactive_c[23]};
    end
  end
  sequence s_sign_read;
    sgn_rd;
  endsequence
  sequence s_strobe_read;
    pwr_valid ##1 !pwr_valid ##1 s_sign_read;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_act_sign: assert property (s_sign_read |=> prdata[0] == $past(seen_reg[1]))
    else $error("active sign bit wrong");
  chk_rea_sign: assert property (s_sign_read |=> prdata[6] == $past(seen_reg[0]))
    else $error("reactive sign bit wrong");
  chk_sign_fresh: assert property (s_strobe_read |=> prdata[0] == $past(active_a[23], 3))
    else $error("sign not refreshed");
  chk_sign_rsvd: assert property (s_sign_read |=> prdata[31:9] == 23'h0)
    else $error("sign reserved bits set");
  chk_comp_rsvd: assert property (cmp_rd |=> prdata[31:10] == 22'h0)
    else $error("comp reserved bits set");
  chk_comp_low: assert property (!comp_volt_a |-> comp_eff_a <= 9'h17f)
    else $error("current code out of range");
  chk_comp_high: assert property (comp_volt_a |-> comp_eff_a >= 9'h180)
    else $error("voltage code out of range");
  chk_eff_hold: assert property ($changed(comp_eff_a) |-> $past(cmp_wr))
    else $error("comp changed without write");
endmodule
bind pcpsr_top pcpsr_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pwr_valid, .active_a, .reactive_c, .comp_eff_a, .comp_volt_a);

// ### sim/pcpsr_pwr_src.sv
// power datapath model feeding new power values
`timescale 1ns/1ps
module pcpsr_pwr_src (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     strobe,
  input wire pcpsr_pkg::pcpsr_pwr_type val [10],
  output logic                         pwr_valid,
  output pcpsr_pkg::pcpsr_pwr_type     pw [10]
);
  // values stand only with the strobe, scrambled after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_valid <= 1'b0;
      pw <= '{default: '0};
    end else begin
      pwr_valid <= strobe;
      for (int i = 0; i < 10; i++) begin
        pw[i] <= strobe ? val[i] : ~pw[i];
      end
    end
  end
endmodule

// ### sim/tb_phase_cal_and_power_sign_regs.sv
// self-checking bench for the compensation and sign registers
`include "pcpsr_params.svh"
`timescale 1ns/1ps
module tb_phase_cal_and_power_sign_regs;
  logic pclk, presetn, psel, penable, pwrite, strobe, pwr_valid, pready, pslverr, irq, err;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  eff_a, eff_b, eff_c, prev, cm, ty, e;
  logic        volt_a, volt_b, volt_c;
  logic [9:0]  c;
  logic [9:0]  codes [8] = '{10'h000, 10'h17f, 10'h180, 10'h1ff, 10'h200, 10'h23f, 10'h3ff, 10'h0a5};
  pcpsr_pkg::pcpsr_pwr_type val [10];
  pcpsr_pkg::pcpsr_pwr_type pw [10];
  int mismatches, num_checks;
  pcpsr_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pwr_valid, .active_a(pw[0]), .active_b(pw[1]), .active_c(pw[2]),
    .reactive_a(pw[3]), .reactive_b(pw[4]), .reactive_c(pw[5]), .reactive_fund_a(pw[6]),
    .apparent_a(pw[7]), .apparent_b(pw[8]), .apparent_c(pw[9]), .comp_eff_a(eff_a),
    .comp_eff_b(eff_b), .comp_eff_c(eff_c), .comp_volt_a(volt_a), .comp_volt_b(volt_b),
    .comp_volt_c(volt_c), .irq);
  pcpsr_pwr_src u_src (.pclk, .presetn, .strobe, .val, .pwr_valid, .pw);
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask
  task automatic fire();
    strobe <= 1'b1;
    @(posedge pclk);
    strobe <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [8:0] esign(logic [8:0] m, logic [8:0] t, logic rs);
    logic [8:0] s;
    logic signed [25:0] sum;
    int pos [3] = '{3, 7, 8};
    s = '0;
    for (int i = 0; i < 3; i++) begin
      s[i] = val[i][23];
      s[i + 4] = val[i + 3][23];
      sum = '0;
      for (int j = 0; j < 3; j++) begin
        if (m[3 * i + j]) begin
          case (t[3 * i +: 3])
            3'h1: sum = sum + val[3 + j];
            3'h2: sum = sum + val[7 + j];
            default: sum = sum + val[j];
          endcase
        end
      end
      s[pos[i]] = sum[25];
    end
    if (rs) s[4] = val[6][23];
    return s;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, strobe} = 5'h00;
    paddr = '0;
    pwdata = '0;
    val = '{default: '0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int p = 0; p < 4; p++) rdc(`PCPSR_IDX_COMP_A + 16'(p), 32'h0);
    foreach (codes[k]) begin
      c = codes[k];
      xfer(1'b1, `PCPSR_IDX_COMP_A, {16'h0, 6'h3f, c});
      rdc(`PCPSR_IDX_COMP_A, {22'h0, c});
      e = c < 10'h180 ? c[8:0] : c < 10'h200 ? c[8:0] - 9'h080 : 9'h180 + {2'h0, c[6:0]};
      check({22'h0, volt_a, eff_a}, {22'h0, c[9], e});
    end
    xfer(1'b1, `PCPSR_IDX_COMP_B, 32'h12c);
    xfer(1'b1, `PCPSR_IDX_COMP_C, 32'h208);
    check({22'h0, volt_b, eff_b}, {22'h0, 1'b0, 9'h12c});
    check({22'h0, volt_c, eff_c}, {22'h0, 1'b1, 9'h188});
    for (int k = 0; k < 8; k++) begin
      ty = {3'(k + 2), 3'(k + 1), 3'(k)};
      cm = {3'(k ^ 5), 3'(7 - k), 3'(k | 1)};
      for (int i = 0; i < 10; i++) val[i] = 24'((i + k) % 3 == 0 ? -(i * 7 + 3) : i * 5 + k + 1);
      xfer(1'b1, `PCPSR_IDX_PULSE, {16'h0, 7'h07, ty});
      xfer(1'b1, `PCPSR_IDX_COMPUTATION_MODE_REG, {23'h0, cm});
      xfer(1'b1, `PCPSR_IDX_ACCUMULATION_MODE_REG, {24'h0, 1'(k), 7'h0});
      fire();
      rdc(`PCPSR_IDX_SIGN, {23'h0, esign(cm, ty, 1'(k))});
    end
    prev = esign(cm, ty, 1'b1);
    xfer(1'b1, `PCPSR_IDX_SIGN, 32'hffff);
    rdc(`PCPSR_IDX_SIGN, {23'h0, prev});
    xfer(1'b1, `PCPSR_IDX_IRQ_CLR, 32'h1ff);
    rdc(`PCPSR_IDX_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, `PCPSR_IDX_IRQ_EN, 32'h001);
    val[0] = -val[0];
    fire();
    check({31'h0, irq}, 32'h1);
    rdc(`PCPSR_IDX_IRQ_STAT, {23'h0, prev ^ esign(cm, ty, 1'b1)});
    rdc(`PCPSR_IDX_SIGN, {23'h0, esign(cm, ty, 1'b1)});
    xfer(1'b1, `PCPSR_IDX_IRQ_EN, 32'h0);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, `PCPSR_IDX_IRQ_CLR, 32'h1ff);
    rdc(`PCPSR_IDX_IRQ_STAT, 32'h0);
    rdc(`PCPSR_IDX_IRQ_CLR, 32'h0);
    xfer(1'b0, 16'he6ff, 32'h0);
    check({rd[30:0], err}, 32'h1);
    complete_run();
  end
endmodule
